// >>> itf_core.sv
// Instruction timing and status-flag unit behind an APB slave
// Assumes a single pclk domain; operands are supplied by software registers
`timescale 1ns/1ps
`default_nettype none
module itf_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic int_block,
  output logic busy
);
  // ==========================================================
  // Helper functions
  function automatic logic [4:0] ffl(input logic [15:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (r == 5'h00 && v[15 - i]) begin
        r = 5'(i + 1);
      end
    end
    return r;
  endfunction : ffl

  function automatic logic [4:0] ffr(input logic [15:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        r = 5'(i + 1);
      end
    end
    return r;
  endfunction : ffr

  // ==========================================================
  // Registers
  logic [15:0] cmd_reg, opa_reg, opb_reg, stat_reg, res_reg;
  logic [15:0] stat_next, res_next;
  itf_pkg::itf_time_t time_reg, time_next;
  logic [13:0] hold_reg, hold_next, loop_reg, loop_next;
  logic [4:0] cnt_reg;
  itf_pkg::itf_state_t st_reg;
  logic go_reg;
  logic [31:0] prdata_reg;

  // ==========================================================
  // APB decode
  wire acc = psel & penable;
  wire wr = acc & pwrite & go_reg;
  wire rd_hit = (paddr == itf_pkg::OFS_CMD) | (paddr == itf_pkg::OFS_OPA) |
    (paddr == itf_pkg::OFS_OPB) | (paddr == itf_pkg::OFS_STAT) |
    (paddr == itf_pkg::OFS_RES) | (paddr == itf_pkg::OFS_TIME) |
    (paddr == itf_pkg::OFS_LOOP);
  wire wr_cmd = wr & (paddr == itf_pkg::OFS_CMD) & (st_reg == itf_pkg::ITF_IDLE);
  wire wr_stat = wr & (paddr == itf_pkg::OFS_STAT);
  logic [31:0] rd_mux;
  always_comb begin
    case (paddr)
      itf_pkg::OFS_CMD: rd_mux = {16'h0000, cmd_reg};
      itf_pkg::OFS_OPA: rd_mux = {16'h0000, opa_reg};
      itf_pkg::OFS_OPB: rd_mux = {16'h0000, opb_reg};
      itf_pkg::OFS_STAT: rd_mux = {16'h0000, stat_reg};
      itf_pkg::OFS_RES: rd_mux = {16'h0000, res_reg};
      itf_pkg::OFS_TIME: rd_mux = {25'h0000000, time_reg};
      itf_pkg::OFS_LOOP: rd_mux = {4'h0, hold_reg, 14'h0000} | {18'h00000, loop_reg};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // ==========================================================
  // Operand decode
  itf_pkg::itf_op_t op;
  assign op = itf_pkg::itf_op_t'(pwdata[itf_pkg::CMD_OP_LSB +: 5]);
  wire [3:0] sel = pwdata[itf_pkg::CMD_SEL_LSB +: 4];
  wire [3:0] bsel = pwdata[itf_pkg::CMD_MOD_LSB + 1] ? opb_reg[3:0] : sel;
  wire to_c = pwdata[itf_pkg::CMD_MOD_LSB];
  wire is_file = pwdata[itf_pkg::CMD_MOD_LSB + 2];
  wire [13:0] lit = pwdata[29:16];
  wire use_reg = pwdata[30];
  wire tbit = opa_reg[bsel];
  wire [1:0] skip_cyc = stat_reg[itf_pkg::B_NEXT2] ? itf_pkg::CYC_THREE : itf_pkg::CYC_TWO;
  wire cin = stat_reg[itf_pkg::B_C];
  wire [16:0] sub = {1'b0, opa_reg} - {1'b0, opb_reg} - {16'h0000, ~cin};
  wire [4:0] hsub = {1'b0, opa_reg[3:0]} - {1'b0, opb_reg[3:0]} - {4'h0, ~cin};
  wire [15:0] q_u = (opb_reg == 16'h0000) ? 16'hFFFF : opa_reg / opb_reg;
  wire signed [15:0] q_s = (opb_reg == 16'h0000) ? 16'sh7FFF :
    $signed(opa_reg) / $signed(opb_reg);
  wire [15:0] lo_adj = (opa_reg[3:0] > 4'h9 || stat_reg[itf_pkg::B_DC]) ? 16'h0006 : 16'h0000;
  wire [15:0] daw1 = {8'h00, opa_reg[7:0]} + lo_adj;
  wire hi_fix = (daw1[7:4] > 4'h9) || cin || daw1[8];
  wire [15:0] daw2 = daw1 + (hi_fix ? 16'h0060 : 16'h0000);
  wire [15:0] chg = opa_reg ^ {opa_reg[14:0], opa_reg[0]};

  // ==========================================================
  // Execute: timing, result and flags
  always_comb begin
    stat_next = stat_reg;
    res_next = res_reg;
    time_next = time_reg;
    hold_next = (hold_reg != 14'h0000) ? hold_reg - 14'h0001 : hold_reg;
    loop_next = loop_reg;
    if (wr_stat) begin
      stat_next = pwdata[15:0] & itf_pkg::STAT_WMASK;
      if (!pwdata[itf_pkg::B_SATA_EN]) stat_next[itf_pkg::B_SA] = stat_reg[itf_pkg::B_SA]; // RL19
      if (!pwdata[itf_pkg::B_SATB_EN]) stat_next[itf_pkg::B_SB] = stat_reg[itf_pkg::B_SB]; // RL19
      if (!(pwdata[itf_pkg::B_SATA_EN] | pwdata[itf_pkg::B_SATB_EN])) begin
        stat_next[itf_pkg::B_SAB] = stat_reg[itf_pkg::B_SAB]; // RL19
      end
    end else if (wr_cmd) begin
      time_next = '{words: 2'h1, cycles: 5'h01};
      case (op)
        itf_pkg::ITF_OP_JNOV, itf_pkg::ITF_OP_JNZ, itf_pkg::ITF_OP_JOV, itf_pkg::ITF_OP_JZ,
        itf_pkg::ITF_OP_JOA, itf_pkg::ITF_OP_JOB, itf_pkg::ITF_OP_JSA,
        itf_pkg::ITF_OP_JSB: begin
          if ((op == itf_pkg::ITF_OP_JNOV && !stat_reg[itf_pkg::B_OV]) || // RL1
              (op == itf_pkg::ITF_OP_JNZ && !stat_reg[itf_pkg::B_Z]) ||
              (op == itf_pkg::ITF_OP_JOV && stat_reg[itf_pkg::B_OV]) ||
              (op == itf_pkg::ITF_OP_JZ && stat_reg[itf_pkg::B_Z]) ||
              (op == itf_pkg::ITF_OP_JOA && stat_reg[itf_pkg::B_OA]) || // RL2
              (op == itf_pkg::ITF_OP_JOB && stat_reg[itf_pkg::B_OB]) ||
              (op == itf_pkg::ITF_OP_JSA && stat_reg[itf_pkg::B_SA]) ||
              (op == itf_pkg::ITF_OP_JSB && stat_reg[itf_pkg::B_SB])) begin
            time_next.cycles = {3'h0, itf_pkg::CYC_TWO};
          end
        end
        itf_pkg::ITF_OP_SKIP_CLR, itf_pkg::ITF_OP_SKIP_SET: begin
          if (tbit == (op == itf_pkg::ITF_OP_SKIP_SET)) begin
            time_next.cycles = {3'h0, skip_cyc}; // RL3 RL20
          end
        end
        itf_pkg::ITF_OP_PROBE, itf_pkg::ITF_OP_PROBE_SET: begin
          if (to_c && !is_file) stat_next[itf_pkg::B_C] = tbit; // RL4 RL5
          else stat_next[itf_pkg::B_Z] = ~tbit; // RL4 RL5
          if (op == itf_pkg::ITF_OP_PROBE_SET) res_next = opa_reg | (16'h0001 << bsel); // RL5
        end
        itf_pkg::ITF_OP_CALL, itf_pkg::ITF_OP_ABSOLUTE_JUMP: begin
          time_next = '{words: use_reg ? 2'h1 : 2'h2, cycles: 5'h02}; // RL6 RL7
        end
        itf_pkg::ITF_OP_CPB: begin
          stat_next[itf_pkg::B_C] = ~sub[16]; // RL8
          stat_next[itf_pkg::B_DC] = ~hsub[4];
          stat_next[itf_pkg::B_N] = sub[15];
          stat_next[itf_pkg::B_OV] = (opa_reg[15] ^ opb_reg[15]) & (opa_reg[15] ^ sub[15]);
          if (sub[15:0] != 16'h0000) stat_next[itf_pkg::B_Z] = 1'b0;
        end
        itf_pkg::ITF_OP_COMPARE_SKIP_EQUAL, itf_pkg::ITF_OP_COMPARE_SKIP_GREATER, itf_pkg::ITF_OP_COMPARE_SKIP_LESS,
        itf_pkg::ITF_OP_COMPARE_SKIP_UNEQUAL: begin
          if ((op == itf_pkg::ITF_OP_COMPARE_SKIP_EQUAL && opa_reg == opb_reg) || // RL9
              (op == itf_pkg::ITF_OP_COMPARE_SKIP_UNEQUAL && opa_reg != opb_reg) ||
              (op == itf_pkg::ITF_OP_COMPARE_SKIP_GREATER && $signed(opa_reg) > $signed(opb_reg)) ||
              (op == itf_pkg::ITF_OP_COMPARE_SKIP_LESS && $signed(opa_reg) < $signed(opb_reg))) begin
            time_next.cycles = {3'h0, skip_cyc}; // RL20
          end
        end
        itf_pkg::ITF_OP_DAW: begin
          res_next = {opa_reg[15:8], daw2[7:0]}; // RL10
          stat_next[itf_pkg::B_C] = hi_fix | daw2[8];
        end
        itf_pkg::ITF_OP_INTERRUPT_HOLD_OFF: hold_next = lit; // RL11
        itf_pkg::ITF_OP_DIVS, itf_pkg::ITF_OP_FRACTIONAL_DIVIDE, itf_pkg::ITF_OP_DIVU,
        itf_pkg::ITF_OP_DIVUD: begin
          time_next.cycles = itf_pkg::DIV_CYC; // RL12 RL13 RL14 RL15
          res_next = (op == itf_pkg::ITF_OP_DIVU || op == itf_pkg::ITF_OP_DIVUD) ? q_u : q_s;
          stat_next[itf_pkg::B_Z] = (res_next == 16'h0000);
          stat_next[itf_pkg::B_C] = (opb_reg != 16'h0000);
          stat_next[itf_pkg::B_OV] = (opb_reg == 16'h0000);
          stat_next[itf_pkg::B_N] = res_next[15];
          if (op == itf_pkg::ITF_OP_DIVU) stat_next[itf_pkg::B_OV] = 1'b0; // RL13
          if (op == itf_pkg::ITF_OP_DIVU || op == itf_pkg::ITF_OP_DIVUD) begin
            stat_next[itf_pkg::B_N] = 1'b0; // RL13 RL14
          end
        end
        itf_pkg::ITF_OP_LOOP: begin
          time_next = '{words: 2'h2, cycles: 5'h02}; // RL16
          loop_next = use_reg ? opa_reg[13:0] : lit;
        end
        itf_pkg::ITF_OP_SIGN_CHANGE_SEARCH: begin
          res_next = {11'h000, ffl({chg[14:0], 1'b0})}; // RL17
          stat_next[itf_pkg::B_C] = (chg[14:0] == 15'h0000);
        end
        itf_pkg::ITF_OP_FIRST_SET_FROM_MSB, itf_pkg::ITF_OP_FIRST_SET_FROM_LSB: begin
          res_next = {11'h000, (op == itf_pkg::ITF_OP_FIRST_SET_FROM_MSB) ? ffl(opa_reg) : ffr(opa_reg)}; // RL18
          stat_next[itf_pkg::B_C] = (opa_reg == 16'h0000);
        end
        default: time_next = time_next;
      endcase
    end
  end

  // ==========================================================
  // State
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_reg <= 16'h0000;
      opa_reg <= 16'h0000;
      opb_reg <= 16'h0000;
      stat_reg <= itf_pkg::STAT_RST;
      res_reg <= 16'h0000;
      time_reg <= '0;
      hold_reg <= 14'h0000;
      loop_reg <= itf_pkg::LOOP_RST;
      cnt_reg <= 5'h00;
      st_reg <= itf_pkg::ITF_IDLE;
      go_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      stat_reg <= stat_next;
      res_reg <= res_next;
      time_reg <= time_next;
      hold_reg <= hold_next;
      loop_reg <= loop_next;
      go_reg <= acc & ~go_reg;
      if (acc & ~go_reg & ~pwrite) prdata_reg <= rd_mux;
      if (wr & (paddr == itf_pkg::OFS_OPA)) opa_reg <= pwdata[15:0];
      if (wr & (paddr == itf_pkg::OFS_OPB)) opb_reg <= pwdata[15:0];
      if (wr_cmd) cmd_reg <= pwdata[15:0];
      case (st_reg)
        itf_pkg::ITF_IDLE: begin
          if (wr_cmd) begin
            cnt_reg <= time_next.cycles - 5'h01;
            if (time_next.cycles != 5'h01) st_reg <= itf_pkg::ITF_BUSY;
          end
        end
        itf_pkg::ITF_BUSY: begin
          cnt_reg <= cnt_reg - 5'h01;
          if (cnt_reg == 5'h01) st_reg <= itf_pkg::ITF_IDLE;
        end
        default: st_reg <= itf_pkg::ITF_IDLE;
      endcase
    end
  end

  logic rd_hit_q;
  logic hold_blk_q;
  logic busy_q;
  assign prdata = prdata_reg;
  assign pready = go_reg;
  assign pslverr = go_reg & ~rd_hit_q;
  assign int_block = hold_blk_q;
  assign busy = busy_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_hit_q <= 1'b1;
      hold_blk_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      rd_hit_q <= rd_hit;
      hold_blk_q <= (hold_next != 14'h0000); // RL11
      busy_q <= (st_reg == itf_pkg::ITF_IDLE) ? (wr_cmd & (time_next.cycles != 5'h01))
        : (cnt_reg != 5'h01);
    end
  end

  // ==========================================================
  // Checks
  a_div_len: assert property (@(posedge pclk) disable iff (!presetn) // RL13
    wr_cmd && op == itf_pkg::ITF_OP_DIVU |=> time_reg.cycles == 5'h12)
    else $error("divide length wrong");
  a_skip_len: assert property (@(posedge pclk) disable iff (!presetn) // RL20
    time_reg.cycles != 5'h00 |-> time_reg.cycles <= 5'h12)
    else $error("cycle count out of range");
  a_divu_flags: assert property (@(posedge pclk) disable iff (!presetn) // RL13
    wr_cmd && op == itf_pkg::ITF_OP_DIVU |=> !stat_reg[itf_pkg::B_N] && !stat_reg[itf_pkg::B_OV])
    else $error("unsigned divide flags wrong");
  a_hold_off: assert property (@(posedge pclk) disable iff (!presetn) // RL11
    wr_cmd && op == itf_pkg::ITF_OP_INTERRUPT_HOLD_OFF && lit > 14'h0002 |=> int_block [*2])
    else $error("hold-off did not block");
  a_busy_div: assert property (@(posedge pclk) disable iff (!presetn) // RL12
    $rose(busy) && time_reg.cycles == 5'h12 |-> busy [*8])
    else $error("busy ended early");
  a_jump_keep: assert property (@(posedge pclk) disable iff (!presetn) // RL1
    wr_cmd && op >= itf_pkg::ITF_OP_JNOV && op <= itf_pkg::ITF_OP_JSB |=> stat_reg == $past(stat_reg))
    else $error("jump changed flags");
  c_div: cover property (@(posedge pclk) disable iff (!presetn) $fell(busy));
  c_hold: cover property (@(posedge pclk) disable iff (!presetn) $rose(int_block));
  c_err: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
endmodule : itf_core
`default_nettype wire

// >>> itf_pkg.sv
// Constants, types and the register map of the instruction timing and flag unit
// Assumes an APB master on pclk; no other clock in the block
// Summary of operation
// [RL1] Jumps on no-wrap, nonzero, wrap, zero: one word, 1 or 2 cycles, flags kept.
// [RL2] Jumps on accumulator A/B overflow and clipping share that one-word 1-or-2 timing.
// [RL3] Bit test skip clear/set: 1 cycle, 2 or 3 when skipping, no flags.
// [RL4] Bit probe copies chosen bit to carry or its complement to zero; file form writes zero only.
// [RL5] Probe then set: old bit into carry or its complement into zero, then bit set, one cycle.
// [RL6] Direct invoke two words, indirect one word, both 2 cycles, flags kept.
// [RL7] Absolute jump literal two words, indirect one word, 2 cycles, flags kept.
// [RL8] Compare minus borrow: a minus b minus not carry, sets DC N OV Z C.
// [RL9] Compare skips test two working registers, 1 cycle or 2/3 when skipping.
// [RL10] Byte decimal adjust yields packed BCD in one cycle, touching only carry.
// [RL11] Interrupt hold-off blocks interrupts for lit14 cycles; itself one cycle.
// [RL12] Signed integer divides take 18 cycles, update N OV Z C, keep DC.
// [RL13] Unsigned 16/16 divide takes 18 cycles, clears N and OV, updates Z C.
// [RL14] Unsigned 32/16 divide takes 18 cycles, clears N, updates OV Z C.
// [RL15] Fractional divide takes 18 cycles and updates N OV Z C.
// [RL16] Hardware loop two words, 2 cycles, repeats body count plus one times.
// [RL17] Sign change search from msb side writes position, one cycle, only carry.
// [RL18] First set searches from msb or lsb write position, one cycle, only carry.
// [RL19] Clipped flags change only when saturation is enabled for that accumulator.
// [RL20] A skip takes 2 cycles over a one-word, 3 over a two-word instruction.
package itf_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_OPA = 8'h04;
  localparam logic [7:0] OFS_OPB = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  localparam logic [7:0] OFS_RES = 8'h10;
  localparam logic [7:0] OFS_TIME = 8'h14;
  localparam logic [7:0] OFS_LOOP = 8'h18;
  // Status register bits
  localparam int B_C = 0;
  localparam int B_Z = 1;
  localparam int B_OV = 2;
  localparam int B_N = 3;
  localparam int B_DC = 4;
  localparam int B_OA = 5;
  localparam int B_OB = 6;
  localparam int B_SA = 7;
  localparam int B_SB = 8;
  localparam int B_OAB = 9;
  localparam int B_SAB = 10;
  localparam int B_SATA_EN = 11;
  localparam int B_SATB_EN = 12;
  localparam int B_NEXT2 = 13;
  localparam logic [15:0] STAT_RST = 16'h0000;
  localparam logic [15:0] STAT_WMASK = 16'h3FFF;
  // Command field positions
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_SEL_LSB = 8;
  localparam int CMD_MOD_LSB = 12;
  // Timing counts
  localparam logic [4:0] DIV_CYC = 5'h12;
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;
  localparam logic [13:0] LOOP_RST = 14'h0000;

  typedef enum logic [4:0] {
    ITF_OP_NOP, ITF_OP_JNOV, ITF_OP_JNZ, ITF_OP_JOV, ITF_OP_JZ, ITF_OP_JOA,
    ITF_OP_JOB, ITF_OP_JSA, ITF_OP_JSB, ITF_OP_SKIP_CLR, ITF_OP_SKIP_SET,
    ITF_OP_PROBE, ITF_OP_PROBE_SET, ITF_OP_CALL, ITF_OP_ABSOLUTE_JUMP, ITF_OP_CPB,
    ITF_OP_COMPARE_SKIP_EQUAL, ITF_OP_COMPARE_SKIP_GREATER, ITF_OP_COMPARE_SKIP_LESS, ITF_OP_COMPARE_SKIP_UNEQUAL, ITF_OP_DAW,
    ITF_OP_INTERRUPT_HOLD_OFF, ITF_OP_DIVS, ITF_OP_DIVU, ITF_OP_DIVUD, ITF_OP_FRACTIONAL_DIVIDE,
    ITF_OP_LOOP, ITF_OP_SIGN_CHANGE_SEARCH, ITF_OP_FIRST_SET_FROM_MSB, ITF_OP_FIRST_SET_FROM_LSB
  } itf_op_t;

  typedef enum logic [1:0] {ITF_IDLE, ITF_BUSY} itf_state_t;

  typedef struct packed {
    logic [15:0] res;
    logic [15:0] stat;
  } itf_out_t;

  typedef struct packed {
    logic [1:0] words;
    logic [4:0] cycles;
  } itf_time_t;
endpackage : itf_pkg

// >>> test_cpu_instr_timing_flags_b_to_g.sv
// Self-checking bench for the instruction timing and status-flag unit
// Assumes itf_pkg and itf_core are compiled first; one pclk domain, APB access only
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin num_errors++; \
  $display("BAD %0t %s got %h exp %h", $time, tname, (got), (exp)); end end
module test_cpu_instr_timing_flags_b_to_g;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, int_block, busy, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int num_errors = 0;
  int n_tests = 0;
  integer seed = 32'h618e;
  string tname;
  int k, t0, cyc = 0;
  itf_pkg::itf_op_t op;
  logic [15:0] m, a, b, st, msk;
  logic [6:0] tm;
  logic [3:0] sel;
  logic tk, bw, rf;
  logic [7:0] jc;
  logic [5:0] sc;
  logic [16:0] df;
  logic [4:0] d4;
  logic [2:0] md_tab [7] = '{3'h1, 3'h0, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
  itf_pkg::itf_op_t sk_ops [6] = '{itf_pkg::ITF_OP_SKIP_CLR, itf_pkg::ITF_OP_SKIP_SET,
    itf_pkg::ITF_OP_COMPARE_SKIP_EQUAL, itf_pkg::ITF_OP_COMPARE_SKIP_GREATER, itf_pkg::ITF_OP_COMPARE_SKIP_LESS, itf_pkg::ITF_OP_COMPARE_SKIP_UNEQUAL};
  itf_pkg::itf_op_t co_ops [5] = '{itf_pkg::ITF_OP_DAW, itf_pkg::ITF_OP_SIGN_CHANGE_SEARCH,
    itf_pkg::ITF_OP_FIRST_SET_FROM_MSB, itf_pkg::ITF_OP_FIRST_SET_FROM_LSB, itf_pkg::ITF_OP_INTERRUPT_HOLD_OFF};
  itf_pkg::itf_op_t dv_ops [4] = '{itf_pkg::ITF_OP_DIVS, itf_pkg::ITF_OP_DIVU,
    itf_pkg::ITF_OP_DIVUD, itf_pkg::ITF_OP_FRACTIONAL_DIVIDE};

  itf_core itf_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .int_block(int_block), .busy(busy));

  // ==========================================================================
  // Clock and cycle count
  always #2 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;

  // ==========================================================================
  // Bus and command helpers
  task automatic end_of_test;
    $display("COUNTS %0d compares %0d mismatches", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d,
                     output logic [31:0] rq, output logic re);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(negedge pclk);
    while (pready !== 1'b1 && n < 16) begin
      @(negedge pclk);
      n++;
    end
    if (pready !== 1'b1) begin
      num_errors++;
      $display("BAD %0t no bus answer", $time);
      end_of_test();
    end else begin
      rq = prdata;
      re = pslverr;
      @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic [31:0] rq;
    logic re;
    apb(1'b1, ad, d, rq, re);
  endtask : wr

  task automatic rd(input logic [7:0] ad, output logic [31:0] rq);
    logic re;
    apb(1'b0, ad, 32'h0, rq, re);
  endtask : rd

  function automatic logic [31:0] mk(input itf_pkg::itf_op_t o, input logic [3:0] s,
                                     input logic [2:0] md, input logic [13:0] lit, input logic r);
    mk = 32'h0;
    mk[4:0] = o;
    mk[11:8] = s;
    mk[14:12] = md;
    mk[29:16] = lit;
    mk[30] = r;
  endfunction : mk

  function automatic logic [6:0] tw(input int w, input int c);
    tw = {w[1:0], c[4:0]};
  endfunction : tw

  // Random operands and flags; both clip enables set so the flag model is exact
  task automatic setup(input logic eq);
    a = 16'($random(seed));
    b = eq ? a : 16'($random(seed));
    m = (16'($random(seed)) & 16'h3FFF) | 16'h1800;
    wr(itf_pkg::OFS_OPA, {16'h0000, a});
    wr(itf_pkg::OFS_OPB, {16'h0000, b});
    wr(itf_pkg::OFS_STAT, {16'h0000, m});
  endtask : setup

  // Issue a command, optionally poke a second one while busy, then read flags and timing
  task automatic exec(input logic [31:0] cmd, input logic poke);
    wr(itf_pkg::OFS_CMD, cmd);
    if (poke) wr(itf_pkg::OFS_CMD, mk(itf_pkg::ITF_OP_NOP, 4'h0, 3'h0, 14'h0, 1'b0));
    k = 0;
    repeat (2) @(posedge pclk);
    while (busy !== 1'b0 && k < 40) begin
      @(posedge pclk);
      k++;
    end
    if (busy !== 1'b0) begin
      num_errors++;
      $display("BAD %0t busy stuck", $time);
      end_of_test();
    end else begin
      rd(itf_pkg::OFS_STAT, q);
      st = q[15:0];
      rd(itf_pkg::OFS_TIME, q);
      tm = q[6:0];
    end
  endtask : exec

  // ==========================================================================
  // Scenarios
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    presetn = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    tname = "reset";
    `CHK({busy, int_block}, 2'b00)
    rd(itf_pkg::OFS_STAT, q);
    `CHK(q, 32'h0)
    apb(1'b1, 8'h40, 32'hFFFFFFFF, q, e);
    `CHK(e, 1'b1)
    apb(1'b0, 8'h40, 32'h0, q, e);
    `CHK({e, q}, {1'b1, 32'h0})
    wr(itf_pkg::OFS_STAT, 32'h00000180);
    rd(itf_pkg::OFS_STAT, q);
    `CHK(q, 32'h0)
    wr(itf_pkg::OFS_STAT, 32'h00001980);
    rd(itf_pkg::OFS_STAT, q);
    `CHK(q, 32'h00001980)
    $display("END %s", tname);
    tname = "jumps";
    for (int i = 0; i < 32; i++) begin
      op = itf_pkg::itf_op_t'(5'(1 + i % 8));
      setup(1'b0);
      jc = {m[itf_pkg::B_SB], m[itf_pkg::B_SA], m[itf_pkg::B_OB], m[itf_pkg::B_OA],
            m[itf_pkg::B_Z], m[itf_pkg::B_OV], !m[itf_pkg::B_Z], !m[itf_pkg::B_OV]};
      tk = jc[i % 8];
      exec(mk(op, 4'h0, 3'h0, 14'h0, 1'b0), 1'b0);
      `CHK(st, m)
      `CHK(tm, tw(1, tk ? 2 : 1))
    end
    $display("END %s", tname);
    tname = "skips";
    for (int i = 0; i < 36; i++) begin
      sel = 4'($random(seed));
      setup(i % 3 == 0);
      sc = {a != b, $signed(a) < $signed(b), $signed(a) > $signed(b), a == b, a[sel], !a[sel]};
      tk = sc[i % 6];
      exec(mk(sk_ops[i % 6], sel, 3'h0, 14'h0, 1'b0), 1'b0);
      `CHK(st, m)
      `CHK(tm, tw(1, tk ? (m[itf_pkg::B_NEXT2] ? 3 : 2) : 1))
    end
    $display("END %s", tname);
    tname = "probes";
    for (int i = 0; i < 14; i++) begin
      op = (i % 7 < 5) ? itf_pkg::ITF_OP_PROBE : itf_pkg::ITF_OP_PROBE_SET;
      sel = 4'($random(seed));
      setup(1'b0);
      tk = md_tab[i % 7][1] ? a[b[3:0]] : a[sel];
      msk = 16'hFFFF;
      if (md_tab[i % 7][0] && !md_tab[i % 7][2]) m[itf_pkg::B_C] = tk;
      else m[itf_pkg::B_Z] = !tk;
      exec(mk(op, sel, md_tab[i % 7], 14'h0, 1'b0), 1'b0);
      `CHK(st & msk, m & msk)
      `CHK(tm, tw(1, 1))
      rd(itf_pkg::OFS_RES, q);
      if (op == itf_pkg::ITF_OP_PROBE_SET) `CHK(q[sel], 1'b1)
    end
    $display("END %s", tname);
    tname = "transfers";
    for (int i = 0; i < 6; i++) begin
      op = i < 2 ? itf_pkg::ITF_OP_CALL : (i < 4 ? itf_pkg::ITF_OP_ABSOLUTE_JUMP : itf_pkg::ITF_OP_LOOP);
      rf = i % 2;
      setup(1'b0);
      exec(mk(op, 4'h0, 3'h0, 14'($random(seed)), rf), 1'b0);
      `CHK(st, m)
      `CHK(tm, tw((rf && op != itf_pkg::ITF_OP_LOOP) ? 1 : 2, 2))
    end
    $display("END %s", tname);
    tname = "borrow";
    for (int i = 0; i < 12; i++) begin
      setup(i % 4 == 0);
      bw = !m[itf_pkg::B_C];
      df = {1'b0, a} - {1'b0, b} - 17'(bw);
      d4 = {1'b0, a[3:0]} - {1'b0, b[3:0]} - 5'(bw);
      m[itf_pkg::B_C] = !df[16];
      m[itf_pkg::B_DC] = !d4[4];
      m[itf_pkg::B_N] = df[15];
      m[itf_pkg::B_OV] = (a[15] != b[15]) && (df[15] != a[15]);
      m[itf_pkg::B_Z] = m[itf_pkg::B_Z] && (df[15:0] == 16'h0000);
      exec(mk(itf_pkg::ITF_OP_CPB, 4'h0, 3'h0, 14'h0, 1'b0), 1'b0);
      `CHK(st, m)
      `CHK(tm, tw(1, 1))
    end
    $display("END %s", tname);
    tname = "carry only";
    for (int i = 0; i < 10; i++) begin
      setup(1'b0);
      msk = co_ops[i % 5] == itf_pkg::ITF_OP_INTERRUPT_HOLD_OFF ? 16'hFFFF : 16'hFFFE;
      exec(mk(co_ops[i % 5], 4'h0, 3'h0, 14'h0, 1'b0), 1'b0);
      `CHK(st & msk, m & msk)
      `CHK(tm, tw(1, 1))
    end
    $display("END %s", tname);
    tname = "hold off";
    t0 = cyc;
    wr(itf_pkg::OFS_CMD, mk(itf_pkg::ITF_OP_INTERRUPT_HOLD_OFF, 4'h0, 3'h0, 14'h0096, 1'b0));
    @(posedge pclk);
    `CHK(int_block, 1'b1)
    k = 0;
    while (int_block !== 1'b0 && k < 400) begin
      @(posedge pclk);
      k++;
    end
    `CHK((cyc - t0 >= 148) && (cyc - t0 <= 160), 1'b1)
    $display("END %s", tname);
    tname = "divide";
    for (int i = 0; i < 9; i++) begin
      op = i == 8 ? itf_pkg::ITF_OP_DIVS : dv_ops[i % 4];
      setup(1'b0);
      if (i == 8) b = 16'h0000;
      if (b == 16'h0000) wr(itf_pkg::OFS_OPB, 32'h0);
      msk = 16'hFFF0;
      if (op == itf_pkg::ITF_OP_DIVU) m[3:2] = 2'b00;
      if (op == itf_pkg::ITF_OP_DIVUD) m[3] = 1'b0;
      if (i == 8) {m[2], m[0]} = 2'b10;
      msk[3:0] = i == 8 ? 4'h5 : (op == itf_pkg::ITF_OP_DIVU ? 4'hC :
                 (op == itf_pkg::ITF_OP_DIVUD ? 4'h8 : 4'h0));
      exec(mk(op, 4'h0, 3'h0, 14'h0, 1'b0), i < 4);
      `CHK(st & msk, m & msk)
      `CHK(tm, tw(1, 18))
      rd(itf_pkg::OFS_RES, q);
      if (op == itf_pkg::ITF_OP_DIVU && b != 16'h0000) `CHK(q[15:0], a / b)
    end
    $display("END %s", tname);
    end_of_test();
  end
endmodule : test_cpu_instr_timing_flags_b_to_g
`default_nettype wire
